// *** verilog/aea_pkg.sv ***
// package for the active energy accumulator: register map, fields, resets, timing
// assumes a single 20 MHz clock domain
package aea_pkg;

  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [7:0] AEA_ADDR_ENERGY      = 8'h01;
  localparam logic [7:0] AEA_ADDR_ENERGY_RC   = 8'h02;
  localparam logic [7:0] AEA_ADDR_WAVE_SEL    = 8'h0d;
  localparam logic [7:0] AEA_ADDR_NOLOAD      = 8'h0e;
  localparam logic [7:0] AEA_ADDR_ACCUM       = 8'h0f;
  localparam logic [7:0] AEA_ADDR_GAIN        = 8'h1d;
  localparam logic [7:0] AEA_ADDR_DIVIDER     = 8'h24;
  localparam logic [7:0] AEA_ADDR_WAVE_DATA   = 8'h30;
  localparam logic [7:0] AEA_ADDR_IRQ_EN_LOW  = 8'hd9;
  localparam logic [7:0] AEA_ADDR_IRQ_EN_MID  = 8'hda;
  localparam logic [7:0] AEA_ADDR_IRQ_EN_HIGH = 8'hdb;
  localparam logic [7:0] AEA_ADDR_IRQ_ST_LOW  = 8'hdc;
  localparam logic [7:0] AEA_ADDR_IRQ_ST_MID  = 8'hdd;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int AEA_BIT_NOLOAD_FLAG  = 0;
  localparam int AEA_BIT_ABS_ENABLE   = 0;
  localparam int AEA_BIT_POS_ENABLE   = 1;
  localparam int AEA_BIT_WAVE_ENABLE  = 5;
  localparam int AEA_BIT_HALF_FULL    = 0;
  localparam int AEA_BIT_OVERFLOW     = 1;
  localparam int AEA_WAVE_SRC_LSB     = 2;
  localparam int AEA_WAVE_RATE_LSB    = 5;
  localparam logic [2:0] AEA_WAVE_SRC_POWER = 3'h0;

  // ********************************************************************
  // widths and reset values
  // ********************************************************************
  localparam int AEA_ACC_W   = 49;
  localparam int AEA_PWR_W   = 24;
  localparam int AEA_FRAC_W  = 16;
  localparam logic [7:0]  AEA_RST_BYTE = 8'h00;
  localparam logic [11:0] AEA_RST_GAIN = 12'h000;
  // full-scale multiplier output magnitude for the no-load comparison
  localparam logic [23:0] AEA_FULL_SCALE = 24'h0ccccd;
  localparam logic [23:0] AEA_THR_1 = 24'h000080; // 0.015%
  localparam logic [23:0] AEA_THR_2 = 24'h000040; // 0.0075%
  localparam logic [23:0] AEA_THR_3 = 24'h00001f; // 0.0037%

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int AEA_CLK_HZ       = 20_000_000;
  localparam int AEA_SAMPLE_CYC   = 5;
  localparam int AEA_WAVE_BASE_HZ = 25_600;
  localparam int AEA_WAVE_BASE_CYC = AEA_CLK_HZ / AEA_WAVE_BASE_HZ;
  localparam int AEA_PULSE_CYC    = 2_000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } aea_bus_s;

endpackage

// *** verilog/aea_active_energy.sv ***
// active energy accumulator: no-load gate, gain, divider, 49-bit accumulator,
// wrap events, waveform sample register and energy pulse output
// assumes power samples are synchronous to clk and the bus master is single cycle
`timescale 1ns/10ps
`default_nettype none

module aea_active_energy
  import aea_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire aea_bus_s           bus,
  output logic [23:0]             rdata,
  input  wire logic signed [23:0] power_lowpass,
  output logic                    irq,
  output logic                    energy_pulse_out_n
);

  // ********************************************************************
  // reset release
  // ********************************************************************
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ********************************************************************
  // configuration registers
  // ********************************************************************
  logic [7:0]  wave_sel_r;
  logic [7:0]  no_load_r;
  logic [7:0]  accum_r;
  logic [11:0] gain_r;
  logic [7:0]  divider_r;
  logic [7:0]  en_low_r;
  logic [7:0]  en_mid_r;
  logic [7:0]  en_high_r;

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wave_sel_r <= AEA_RST_BYTE;
      no_load_r  <= AEA_RST_BYTE;
      accum_r    <= AEA_RST_BYTE;
      gain_r     <= AEA_RST_GAIN;
      divider_r  <= AEA_RST_BYTE;
      en_low_r   <= AEA_RST_BYTE;
      en_mid_r   <= AEA_RST_BYTE;
      en_high_r  <= AEA_RST_BYTE;
    end else if (bus.wr) begin
      case (bus.addr)
        AEA_ADDR_WAVE_SEL:    wave_sel_r <= bus.wdata;
        AEA_ADDR_NOLOAD:      no_load_r  <= bus.wdata;
        AEA_ADDR_ACCUM:       accum_r    <= bus.wdata;
        AEA_ADDR_GAIN:        gain_r     <= {gain_r[11:8], bus.wdata};
        AEA_ADDR_GAIN + 8'h80: gain_r    <= {bus.wdata[3:0], gain_r[7:0]};
        AEA_ADDR_DIVIDER:     divider_r  <= bus.wdata;
        AEA_ADDR_IRQ_EN_LOW:  en_low_r   <= bus.wdata;
        AEA_ADDR_IRQ_EN_MID:  en_mid_r   <= bus.wdata;
        AEA_ADDR_IRQ_EN_HIGH: en_high_r  <= bus.wdata;
        default: begin
        end
      endcase
    end
  end

  // ********************************************************************
  // sample timing
  // ********************************************************************
  logic [2:0] phase_r;
  logic       sample_tick;
  assign sample_tick = (phase_r == 3'(AEA_SAMPLE_CYC - 1));
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= sample_tick ? 3'h0 : phase_r + 3'h1;
    end
  end

  // ********************************************************************
  // gain, no-load and mode selection
  // ********************************************************************
  logic signed [36:0] gained_full;
  logic signed [23:0] gained;
  logic [23:0]        magnitude;
  logic [23:0]        threshold;
  logic               below_thr;
  logic               pos_only;
  logic               abs_mode;
  logic signed [24:0] contrib;

  assign gained_full = (37'(power_lowpass) <<< 12) + 37'(power_lowpass) * 37'(signed'(gain_r));
  assign gained      = gained_full[35:12];
  assign magnitude   = gained[23] ? 24'(-gained) : gained;

  always_comb begin
    case (no_load_r[1:0])
      2'h1:    threshold = AEA_THR_1;
      2'h2:    threshold = AEA_THR_2;
      2'h3:    threshold = AEA_THR_3;
      default: threshold = 24'h000000;
    endcase
  end

  assign below_thr = magnitude < threshold;
  assign pos_only  = accum_r[AEA_BIT_POS_ENABLE];
  assign abs_mode  = accum_r[AEA_BIT_ABS_ENABLE] && !pos_only;

  always_comb begin
    if (below_thr) begin
      contrib = 25'h0;
    end else if (pos_only && gained[23]) begin
      contrib = 25'h0;
    end else if (abs_mode) begin
      contrib = 25'(magnitude);
    end else begin
      contrib = 25'(gained);
    end
  end

  // ********************************************************************
  // divider and accumulator
  // ********************************************************************
  logic [7:0]         div_eff;
  logic signed [40:0] scaled;
  logic [48:0]        acc_r;
  logic [48:0]        acc_nxt;
  logic               rc_read;

  assign div_eff = (divider_r == 8'h00) ? 8'h01 : divider_r;
  // accumulator carries 16 fraction bits below the sample lsb
  assign scaled  = (41'(contrib) <<< AEA_FRAC_W) / signed'(41'({1'b0, div_eff}));
  assign acc_nxt = acc_r + 49'(scaled);
  assign rc_read = bus.rd && (bus.addr == AEA_ADDR_ENERGY_RC);

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      acc_r <= 49'h0;
    end else if (rc_read) begin
      acc_r <= {24'h000000, sample_tick ? acc_nxt[24:0] : acc_r[24:0]};
    end else if (sample_tick) begin
      acc_r <= acc_nxt;
    end
  end

  // ********************************************************************
  // events and status
  // ********************************************************************
  logic [23:0] top_old;
  logic [23:0] top_new;
  logic        ev_half;
  logic        ev_wrap;
  logic [7:0]  st_low_r;
  logic [7:0]  st_mid_r;
  logic        clr_low;
  logic        clr_mid;

  assign top_old = acc_r[48:25];
  assign top_new = acc_nxt[48:25];
  assign ev_half = sample_tick && (top_old[23] == top_new[23]) && (top_old[22] != top_new[22]);
  assign ev_wrap = sample_tick && (top_old[23] != top_new[23]) && (top_old[22] == top_old[23] ? 1'b0 : 1'b1);
  assign clr_low = bus.wr && (bus.addr == AEA_ADDR_IRQ_ST_LOW);
  assign clr_mid = bus.wr && (bus.addr == AEA_ADDR_IRQ_ST_MID);

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_low_r <= 8'h00;
    end else begin
      // write one clears, a set in the same cycle wins
      st_low_r[AEA_BIT_NOLOAD_FLAG] <= (below_thr && no_load_r[1:0] != 2'h0) ||
        (st_low_r[AEA_BIT_NOLOAD_FLAG] && !(clr_low && bus.wdata[AEA_BIT_NOLOAD_FLAG]));
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_mid_r <= 8'h00;
    end else begin
      st_mid_r[AEA_BIT_HALF_FULL] <= ev_half ||
        (st_mid_r[AEA_BIT_HALF_FULL] && !(clr_mid && bus.wdata[AEA_BIT_HALF_FULL]));
      st_mid_r[AEA_BIT_OVERFLOW] <= ev_wrap ||
        (st_mid_r[AEA_BIT_OVERFLOW] && !(clr_mid && bus.wdata[AEA_BIT_OVERFLOW]));
    end
  end

  assign irq = |(st_low_r & en_low_r & 8'h01) | |(st_mid_r & en_mid_r & 8'h03);

  // ********************************************************************
  // waveform sample register
  // ********************************************************************
  logic [15:0] wave_cnt_r;
  logic [15:0] wave_period;
  logic        wave_tick;
  logic [23:0] wave_r;

  assign wave_period = 16'(AEA_WAVE_BASE_CYC) << wave_sel_r[AEA_WAVE_RATE_LSB +: 2];
  assign wave_tick   = (wave_cnt_r >= wave_period - 16'h1);
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wave_cnt_r <= 16'h0;
      wave_r     <= 24'h000000;
    end else begin
      wave_cnt_r <= wave_tick ? 16'h0 : wave_cnt_r + 16'h1;
      if (wave_tick && en_high_r[AEA_BIT_WAVE_ENABLE] &&
          wave_sel_r[AEA_WAVE_SRC_LSB +: 3] == AEA_WAVE_SRC_POWER) begin
        wave_r <= gained;
      end
    end
  end

  // ********************************************************************
  // energy pulse output
  // ********************************************************************
  logic [31:0] pulse_acc_r;
  logic [15:0] pulse_len_r;
  logic [31:0] pulse_sum;
  assign pulse_sum = pulse_acc_r + 32'(unsigned'(contrib[23:0])) * 32'(contrib >= 0);

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pulse_acc_r        <= 32'h0;
      pulse_len_r        <= 16'h0;
      energy_pulse_out_n <= 1'b1;
    end else begin
      if (sample_tick) begin
        pulse_acc_r <= {1'b0, pulse_sum[30:0]};
      end
      if (sample_tick && pulse_sum[31] != pulse_acc_r[31] || sample_tick && pulse_sum[30] != pulse_acc_r[30]) begin
        pulse_len_r        <= 16'(AEA_PULSE_CYC);
        energy_pulse_out_n <= 1'b0;
      end else if (pulse_len_r != 16'h0) begin
        pulse_len_r        <= pulse_len_r - 16'h1;
        energy_pulse_out_n <= (pulse_len_r == 16'h1);
      end
    end
  end

  // ********************************************************************
  // read port
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata <= 24'h000000;
    end else if (bus.rd) begin
      case (bus.addr)
        AEA_ADDR_ENERGY:      rdata <= acc_r[48:25];
        AEA_ADDR_ENERGY_RC:   rdata <= acc_r[48:25];
        AEA_ADDR_WAVE_SEL:    rdata <= {16'h0, wave_sel_r};
        AEA_ADDR_NOLOAD:      rdata <= {16'h0, no_load_r};
        AEA_ADDR_ACCUM:       rdata <= {16'h0, accum_r};
        AEA_ADDR_GAIN:        rdata <= {12'h0, gain_r};
        AEA_ADDR_DIVIDER:     rdata <= {16'h0, divider_r};
        AEA_ADDR_WAVE_DATA:   rdata <= wave_r;
        AEA_ADDR_IRQ_EN_LOW:  rdata <= {16'h0, en_low_r};
        AEA_ADDR_IRQ_EN_MID:  rdata <= {16'h0, en_mid_r};
        AEA_ADDR_IRQ_EN_HIGH: rdata <= {16'h0, en_high_r};
        AEA_ADDR_IRQ_ST_LOW:  rdata <= {16'h0, st_low_r};
        AEA_ADDR_IRQ_ST_MID:  rdata <= {16'h0, st_mid_r};
        default:              rdata <= 24'h000000;
      endcase
    end else begin
      rdata <= 24'h000000;
    end
  end

endmodule

`default_nettype wire

// *** tb/aea_active_energy_properties.sv ***
// checker for the active energy accumulator, watching its top ports only
// assumes the single clk domain and the register map of aea_pkg
`timescale 1ns/10ps
`default_nettype none

module aea_active_energy_properties
  import aea_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire aea_bus_s           bus,
  input wire logic [23:0]        rdata,
  input wire logic signed [23:0] power_lowpass,
  input wire logic               irq,
  input wire logic               energy_pulse_out_n
);
  // ********************************************************************
  // shadows of written configuration bytes
  // ********************************************************************
  logic [7:0] nl_r;
  logic [7:0] acc_r;
  logic [7:0] div_r;
  logic [7:0] enl_r;
  logic [7:0] enm_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nl_r  <= 8'h00;
      acc_r <= 8'h00;
      div_r <= 8'h00;
      enl_r <= 8'h00;
      enm_r <= 8'h00;
    end else if (bus.wr) begin
      if (bus.addr == AEA_ADDR_NOLOAD) nl_r <= bus.wdata;
      if (bus.addr == AEA_ADDR_ACCUM) acc_r <= bus.wdata;
      if (bus.addr == AEA_ADDR_DIVIDER) div_r <= bus.wdata;
      if (bus.addr == AEA_ADDR_IRQ_EN_LOW) enl_r <= bus.wdata;
      if (bus.addr == AEA_ADDR_IRQ_EN_MID) enm_r <= bus.wdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rdata_idle; !$past(bus.rd) |-> rdata == 24'h0; endproperty
  property p_unmapped; bus.rd && bus.addr == 8'h7f |=> rdata == 24'h0; endproperty
  property p_nl_rb; bus.rd && bus.addr == AEA_ADDR_NOLOAD |=> rdata[1:0] == $past(nl_r[1:0]);
  endproperty
  property p_acc_rb; bus.rd && bus.addr == AEA_ADDR_ACCUM |=> rdata[1:0] == $past(acc_r[1:0]);
  endproperty
  property p_div_rb; bus.rd && bus.addr == AEA_ADDR_DIVIDER |=> rdata[7:0] == $past(div_r);
  endproperty
  property p_irq_off; enl_r[0] == 1'b0 && enm_r[1:0] == 2'h0 |-> !irq; endproperty
  property p_irq_hold; irq && !bus.wr |=> irq; endproperty
  property p_pulse_low; $fell(energy_pulse_out_n) |=> !energy_pulse_out_n [*8]; endproperty

  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside the read slot");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_nl_rb: assert property (p_nl_rb)
    else $error("no-load code readback wrong");
  a_acc_rb: assert property (p_acc_rb)
    else $error("accumulation mode readback wrong");
  a_div_rb: assert property (p_div_rb)
    else $error("divider readback wrong");
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with all sources disabled");
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without a write");
  a_pulse_low: assert property (p_pulse_low)
    else $error("energy pulse too short");

  c_irq: cover property ($rose(irq));
  c_pulse: cover property ($fell(energy_pulse_out_n));
  c_rc: cover property (bus.rd && bus.addr == AEA_ADDR_ENERGY_RC);
endmodule

bind aea_active_energy aea_active_energy_properties aea_active_energy_properties_inst (
  .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .power_lowpass(power_lowpass),
  .irq(irq), .energy_pulse_out_n(energy_pulse_out_n));
`default_nettype wire

// *** tb/aea_mcu_model.sv ***
// bus master model of the microcontroller core for the energy block
// assumes single-cycle strobes changed right after a rising edge
`timescale 1ns/10ps
`default_nettype none

module aea_mcu_model
  import aea_pkg::*;
(
  input  wire logic clk,
  output var aea_bus_s bus
);
  // ********************************************************************
  // one register access, strobe high for exactly one cycle
  // ********************************************************************
  initial bus = '0;

  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '{addr: a ^ 8'hff, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
endmodule
`default_nettype wire

// *** tb/tb_aea_active_energy.sv ***
// self-checking bench for the active energy accumulator
// assumes the design, its bound checker and the bus master model
`timescale 1ns/10ps
`default_nettype none

module tb_aea_active_energy
  import aea_pkg::*;
;
  typedef struct {logic [23:0] val; int kind;} aea_exp_s;
  localparam logic [7:0] regs [6] = '{AEA_ADDR_NOLOAD, AEA_ADDR_ACCUM, AEA_ADDR_DIVIDER,
    AEA_ADDR_IRQ_EN_LOW, AEA_ADDR_IRQ_EN_MID, AEA_ADDR_IRQ_EN_HIGH};
  localparam logic [7:0] masks [6] = '{8'h03, 8'h03, 8'hff, 8'h01, 8'h03, 8'h20};
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic signed [23:0] pwr = 24'sh0;
  aea_bus_s           bus;
  logic [23:0]        rdata;
  logic               irq;
  logic               pulse_n;
  logic               rd_q = 1'b0;
  int                 num_errors = 0;
  int                 checks = 0;
  int                 pulses = 0;
  int                 mark = 0;
  aea_exp_s           exp_q[$];
  aea_exp_s           e;

  aea_active_energy aea_active_energy_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .power_lowpass(pwr), .irq(irq), .energy_pulse_out_n(pulse_n));
  aea_mcu_model aea_mcu_model_inst (.clk(clk), .bus(bus));

  initial forever #25 clk = ~clk;
  always @(negedge pulse_n) pulses++;

  // ********************************************************************
  // helpers
  // ********************************************************************
  task automatic check(input logic [23:0] got, input logic [23:0] want);
    checks++;
    if (got !== want) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    aea_mcu_model_inst.access(1'b1, a, d);
  endtask
  // kind 0 exact, 1 positive, 2 negative, 3 ignored
  task automatic rd(input logic [7:0] a, input logic [23:0] v, input int k);
    exp_q.push_back('{val: v, kind: k});
    aea_mcu_model_inst.access(1'b0, a, 8'h00);
  endtask
  task automatic run(input logic signed [23:0] p, input int n);
    pwr <= p;
    repeat (n) @(posedge clk);
  endtask
  // drain in-flight samples, clear, accumulate, then read and clear
  task automatic phase(input logic signed [23:0] p, input int k);
    run(24'sh0, 40);
    rd(AEA_ADDR_ENERGY_RC, 24'h0, 3);
    run(p, 1000);
    rd(AEA_ADDR_ENERGY_RC, 24'h0, k);
  endtask
  function automatic logic signed [23:0] big();
    return {8'h0c, 16'($urandom)};
  endfunction
  function automatic logic signed [23:0] under(input int m);
    return (m == 1 ? AEA_THR_1 : m == 2 ? AEA_THR_2 : AEA_THR_3) - 24'h1;
  endfunction
  task automatic close_out;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      case (e.kind)
        0: check(rdata, e.val);
        1: check({23'h0, !rdata[23] && rdata != 24'h0}, 24'h1);
        2: check({23'h0, rdata[23]}, 24'h1);
        default: ;
      endcase
    end
    rd_q <= bus.rd;
  end

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    close_out;
  end

  // ********************************************************************
  // scenarios
  // ********************************************************************
  initial begin
    logic [7:0] v;
    logic [23:0] w;
    void'($urandom(71));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) rd(regs[i], 24'h0, 0);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom) & masks[i];
      wr(regs[i], v);
      rd(regs[i], {16'h0, v}, 0);
      wr(regs[i], 8'h00);
    end
    // random no-load codes above latched the flag while power was zero
    wr(AEA_ADDR_IRQ_ST_LOW, 8'h01);
    wr(8'h7f, 8'ha5);
    rd(8'h7f, 24'h0, 0);
    phase(under(3), 1);
    rd(AEA_ADDR_IRQ_ST_LOW, 24'h0, 0);
    phase(big(), 1);
    phase(-big(), 2);
    for (int m = 1; m < 4; m++) begin
      wr(AEA_ADDR_ACCUM, 8'(m));
      wr(AEA_ADDR_NOLOAD, 8'(m));
      run(24'sh0, 40);
      mark = pulses;
      phase(-big(), m == 1 ? 1 : 0);
      if (m > 1) check(24'(pulses), 24'(mark));
      rd(AEA_ADDR_IRQ_ST_LOW, 24'h1, 0);
      wr(AEA_ADDR_IRQ_ST_LOW, 8'h01);
      wr(AEA_ADDR_ACCUM, 8'h00);
      phase(under(m), 0);
      rd(AEA_ADDR_IRQ_ST_LOW, 24'h1, 0);
    end
    // waveform register follows power only while the sample enable is set
    wr(AEA_ADDR_IRQ_EN_HIGH, 8'h20);
    run(big(), 800);
    w = pwr;
    rd(AEA_ADDR_WAVE_DATA, w, 0);
    wr(AEA_ADDR_IRQ_EN_HIGH, 8'h00);
    run(-big(), 800);
    rd(AEA_ADDR_WAVE_DATA, w, 0);
    wr(AEA_ADDR_IRQ_EN_LOW, 8'h01);
    run(24'sh0, 20);
    #1 check({23'h0, irq}, 24'h1);
    run(big(), 20);
    wr(AEA_ADDR_IRQ_ST_LOW, 8'h01);
    run(big(), 5);
    #1 check({23'h0, irq}, 24'h0);
    wr(AEA_ADDR_IRQ_EN_LOW, 8'h00);
    wr(AEA_ADDR_IRQ_EN_MID, 8'h01);
    wr(AEA_ADDR_GAIN, 8'hff);
    wr(AEA_ADDR_GAIN + 8'h80, 8'h07);
    run(24'sh0, 40);
    rd(AEA_ADDR_ENERGY_RC, 24'h0, 3);
    mark = pulses;
    pwr <= big();
    for (int i = 0; i < 11000 && irq !== 1'b1; i++) @(posedge clk);
    #1 check({23'h0, irq}, 24'h1);
    rd(AEA_ADDR_IRQ_ST_MID, 24'h1, 0);
    wr(AEA_ADDR_IRQ_EN_MID, 8'h02);
    wr(AEA_ADDR_IRQ_ST_MID, 8'h01);
    for (int i = 0; i < 11000 && irq !== 1'b1; i++) @(posedge clk);
    #1 check({23'h0, irq}, 24'h1);
    rd(AEA_ADDR_ENERGY, 24'h0, 2);
    check(24'(pulses > mark), 24'h1);
    repeat (3) @(posedge clk);
    close_out;
  end
endmodule
`default_nettype wire
